// *** hw/ilm_params.svh ***
`ifndef ILM_PARAMS_SVH
`define ILM_PARAMS_SVH

// Register byte offsets on the APB slave
`define ILM_OFF_LVL_A 12'h000
`define ILM_OFF_LVL_B 12'h004
`define ILM_OFF_LVL_C 12'h008
`define ILM_OFF_LVL_D 12'h00c
`define ILM_OFF_LVL_E 12'h010
`define ILM_OFF_BLOCK 12'h014

// Level field positions (upper bit of each 2-bit field)
`define ILM_FLD3_HI 7
`define ILM_FLD2_HI 5
`define ILM_FLD1_HI 3
`define ILM_FLD0_HI 1

// Mask register control bits
`define ILM_BLK_HI_BIT 1
`define ILM_BLK_LO_BIT 0

// Reset values and fixed read values
`define ILM_LVL_RST 8'h00
`define ILM_BLK_RST 2'h0
`define ILM_BLK_RSVD 6'h3f
`define ILM_LVL_E_KEEP 8'hf0
`define ILM_RD_ZERO 32'h0000_0000

// Sizes
`define ILM_NUM_REG 5
`define ILM_NUM_SRC 18

`endif

// *** hw/ilm_pkg.sv ***
package ilm_pkg;

   // Decoded mask level of a source
   typedef enum logic [1:0] {
      lvl_0,
      lvl_1,
      lvl_2
   } ilm_level_t;

   // Index of a maskable source group, in vector order
   typedef logic [4:0] ilm_src_id_t;

endpackage

// *** hw/ilm_level_decode.sv ***
`timescale 1ns/1ns

module ilm_level_decode
   import ilm_pkg::*;
(
   // Programmed fields
   input wire logic [1:0] level_field,
   input wire logic [1:0] block_field,
   // Decoded result
   output ilm_level_t level,
   output logic blocked
);

   always_comb begin
      // [R3] Field decode
      if (level_field[1]) begin
         level = lvl_2;
      end else if (level_field[0]) begin
         level = lvl_1;
      end else begin
         level = lvl_0;
      end
      // [R7] Level blocking
      if (block_field[1]) begin
         blocked = (level != lvl_2);
      end else if (block_field[0]) begin
         blocked = (level == lvl_0);
      end else begin
         blocked = 1'b0;
      end
   end

endmodule

// *** hw/ilm_top.sv ***
// Notes on behaviour
// [R1] Every maskable source gets a programmable level 0 to 2; NMI and break have none.
// [R2] The first four level registers hold four 2-bit fields at 7:6, 5:4, 3:2, 1:0, the fifth only 7:6 and 5:4, one per source group.
// [R3] A field of 00 is level 0, 01 is level 1, and 1x is level 2 with the low bit ignored.
// [R4] The low four bits of the fifth level register are reserved and assign no level.
// [R5] An 8-bit read/write mask register selects one of three masking levels by its two low bits.
// [R6] Mask register bits 7 to 2 always read as one and ignore writes.
// [R7] Mask 1x blocks levels 1 and 0, mask 01 blocks level 0 only, mask 00 passes everything.
// [R8] After reset the mask bits and all level fields are zero.
// [R9] NMI is always passed as the top request, blocked by neither mask.
// [R10] Among forwarded sources of equal level the lower vector number wins.
// [R11] A request is forwarded only if its level is not blocked; higher levels win.
`timescale 1ns/1ns
`include "ilm_params.svh"

module ilm_top
   import ilm_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Requests from source flag logic
   input wire logic [`ILM_NUM_SRC-1:0] src_req,
   input wire logic nmi_req,
   input wire logic brk_req,
   input wire logic cpu_imask,
   // Filtered request to the core
   output logic irq_valid,
   output logic irq_nmi,
   output logic irq_brk,
   output ilm_src_id_t irq_src,
   output ilm_level_t irq_level
);

   localparam logic [11:0] LVL_OFF [`ILM_NUM_REG] = '{
      `ILM_OFF_LVL_A,
      `ILM_OFF_LVL_B,
      `ILM_OFF_LVL_C,
      `ILM_OFF_LVL_D,
      `ILM_OFF_LVL_E
   };

   // Register state
   logic [7:0] lvl_q [`ILM_NUM_REG];
   logic [7:0] lvl_d [`ILM_NUM_REG];
   logic [1:0] blk_q;
   logic [1:0] blk_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic wr_en;
   logic rd_hit;
   logic [7:0] rd_byte;

   // Request path state
   logic irq_valid_q;
   logic irq_valid_d;
   logic irq_nmi_q;
   logic irq_nmi_d;
   logic irq_brk_q;
   logic irq_brk_d;
   ilm_src_id_t irq_src_q;
   ilm_src_id_t irq_src_d;
   ilm_level_t irq_level_q;
   ilm_level_t irq_level_d;
   ilm_level_t src_lvl [`ILM_NUM_SRC];
   logic [`ILM_NUM_SRC-1:0] src_blk;
   logic [`ILM_NUM_SRC-1:0] fwd;
   logic best_found;
   ilm_level_t best_lvl;
   ilm_src_id_t best_id;

   // APB access and register writes
   always_comb begin
      wr_en = psel && penable && pready_q && pwrite;
      rd_hit = 1'b0;
      rd_byte = 8'h00;
      for (int r = 0; r < `ILM_NUM_REG; r++) begin
         if (paddr == LVL_OFF[r]) begin
            rd_hit = 1'b1;
            rd_byte = lvl_q[r];
         end
      end
      if (paddr == `ILM_OFF_BLOCK) begin
         rd_hit = 1'b1;
         // [R6] Reserved ones
         rd_byte = {`ILM_BLK_RSVD, blk_q};
      end
      // Answer one cycle after setup
      pready_d = psel && !penable;
      pslverr_d = psel && !penable && !rd_hit;
      prdata_d = `ILM_RD_ZERO;
      if (psel && !penable && !pwrite) begin
         prdata_d[7:0] = rd_byte;
      end
      for (int r = 0; r < `ILM_NUM_REG; r++) begin
         lvl_d[r] = lvl_q[r];
         // [R2] Field write
         if (wr_en && paddr == LVL_OFF[r]) begin
            lvl_d[r] = pwdata[7:0];
         end
      end
      // [R4] Reserved low bits
      lvl_d[`ILM_NUM_REG-1] = lvl_d[`ILM_NUM_REG-1] & `ILM_LVL_E_KEEP;
      blk_d = blk_q;
      // [R5] Mask write
      if (wr_en && paddr == `ILM_OFF_BLOCK) begin
         blk_d = pwdata[1:0];
      end
   end

   // [R8] Reset values
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int r = 0; r < `ILM_NUM_REG; r++) begin
            lvl_q[r] <= `ILM_LVL_RST;
         end
         blk_q <= `ILM_BLK_RST;
         prdata_q <= `ILM_RD_ZERO;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         for (int r = 0; r < `ILM_NUM_REG; r++) begin
            lvl_q[r] <= lvl_d[r];
         end
         blk_q <= blk_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // [R1] Per-source level and block decode
   genvar g;
   generate
      for (g = 0; g < `ILM_NUM_SRC; g++) begin : gen_src
         ilm_level_decode u_dec (
            .level_field(lvl_q[g / 4][7 - 2 * (g % 4) -: 2]),
            .block_field(blk_q),
            .level(src_lvl[g]),
            .blocked(src_blk[g])
         );
         // [R11] Forward unblocked
         assign fwd[g] = src_req[g] && !src_blk[g] && !cpu_imask;
      end
   endgenerate

   // Arbitration and output select
   always_comb begin
      best_found = 1'b0;
      best_lvl = lvl_0;
      best_id = '0;
      // [R10] Equal level, low index wins
      for (int i = `ILM_NUM_SRC - 1; i >= 0; i--) begin
         if (fwd[i] && (!best_found || src_lvl[i] >= best_lvl)) begin
            best_found = 1'b1;
            best_lvl = src_lvl[i];
            best_id = 5'(i);
         end
      end
      irq_valid_d = 1'b0;
      irq_nmi_d = 1'b0;
      irq_brk_d = 1'b0;
      irq_src_d = '0;
      irq_level_d = lvl_0;
      // [R9] NMI first, unmasked
      if (nmi_req) begin
         irq_valid_d = 1'b1;
         irq_nmi_d = 1'b1;
         irq_level_d = lvl_2;
      end else if (brk_req && !cpu_imask) begin
         irq_valid_d = 1'b1;
         irq_brk_d = 1'b1;
         irq_level_d = lvl_2;
      end else if (best_found) begin
         irq_valid_d = 1'b1;
         irq_src_d = best_id;
         irq_level_d = best_lvl;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_valid_q <= 1'b0;
         irq_nmi_q <= 1'b0;
         irq_brk_q <= 1'b0;
         irq_src_q <= '0;
         irq_level_q <= lvl_0;
      end else begin
         irq_valid_q <= irq_valid_d;
         irq_nmi_q <= irq_nmi_d;
         irq_brk_q <= irq_brk_d;
         irq_src_q <= irq_src_d;
         irq_level_q <= irq_level_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq_valid = irq_valid_q;
   assign irq_nmi = irq_nmi_q;
   assign irq_brk = irq_brk_q;
   assign irq_src = irq_src_q;
   assign irq_level = irq_level_q;

   // Checks
   logic started_q;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         started_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
      end
   end

   AST_RESET_ZERO: assert property ( // [R8]
      @(posedge mclk) disable iff (sys_rst)
      !started_q |-> (blk_q == `ILM_BLK_RST && lvl_q[0] == `ILM_LVL_RST && lvl_q[4] == `ILM_LVL_RST))
      else $error("Level or mask state not zero after reset");

   AST_FIELD_WRITE: assert property ( // [R2]
      @(posedge mclk) disable iff (sys_rst)
      (wr_en && paddr == `ILM_OFF_LVL_B) |=> (lvl_q[1] == $past(pwdata[7:0])))
      else $error("Level register write not stored");

   AST_E_RESERVED: assert property ( // [R4]
      @(posedge mclk) disable iff (sys_rst)
      (psel && !penable && !pwrite && paddr == `ILM_OFF_LVL_E) |=> (prdata_q[3:0] == 4'h0))
      else $error("Reserved level bits read nonzero");

   AST_MASK_WRITE: assert property ( // [R5]
      @(posedge mclk) disable iff (sys_rst)
      (wr_en && paddr == `ILM_OFF_BLOCK) |=> (blk_q == $past(pwdata[1:0])))
      else $error("Mask register write not stored");

   AST_MASK_ONES: assert property ( // [R6]
      @(posedge mclk) disable iff (sys_rst)
      (psel && !penable && !pwrite && paddr == `ILM_OFF_BLOCK)
      |=> (prdata_q[7:0] == {`ILM_BLK_RSVD, $past(blk_q)} && pready_q))
      else $error("Mask register read wrong");

   AST_DECODE_HI: assert property ( // [R3]
      @(posedge mclk) disable iff (sys_rst)
      lvl_q[0][7] |-> (src_lvl[0] == lvl_2))
      else $error("Upper field bit did not give level 2");

   AST_BLOCK_HI: assert property ( // [R7]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !brk_req && blk_q[1])
      |=> !(irq_valid_q && irq_level_q != lvl_2))
      else $error("Level 1 or 0 request passed under high mask");

   AST_NMI_PASS: assert property ( // [R9]
      @(posedge mclk) disable iff (sys_rst)
      nmi_req |=> (irq_valid_q && irq_nmi_q && !irq_brk_q))
      else $error("NMI not forwarded");

   AST_LOW_INDEX: assert property ( // [R10]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !brk_req && fwd[0] && src_lvl[0] == lvl_2) |=> (irq_src_q == 5'h00))
      else $error("Lowest source at top level did not win");

   AST_NONE_FWD: assert property ( // [R11]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !(brk_req && !cpu_imask) && fwd == '0) |=> !irq_valid_q)
      else $error("Request forwarded with nothing eligible");

   AST_DECODE_MID: assert property ( // [R3]
      @(posedge mclk) disable iff (sys_rst)
      (lvl_q[0][3:2] == 2'h1) |-> (src_lvl[2] == lvl_1))
      else $error("Field 01 did not give level 1");

   AST_DECODE_LOW: assert property ( // [R3]
      @(posedge mclk) disable iff (sys_rst)
      (lvl_q[0][1:0] == 2'h0) |-> (src_lvl[3] == lvl_0))
      else $error("Field 00 did not give level 0");

   AST_BLOCK_LO: assert property ( // [R7]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !brk_req && blk_q == 2'h1)
      |=> !(irq_valid_q && irq_level_q == lvl_0))
      else $error("Level 0 request passed under low mask");

   AST_PASS_ALL: assert property ( // [R7]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !brk_req && !cpu_imask && blk_q == 2'h0 && src_req[3]) |=> irq_valid_q)
      else $error("Request dropped with mask open");

   AST_E_WRITE: assert property ( // [R4]
      @(posedge mclk) disable iff (sys_rst)
      (wr_en && paddr == `ILM_OFF_LVL_E) |=> (lvl_q[4] == ($past(pwdata[7:0]) & `ILM_LVL_E_KEEP)))
      else $error("Fifth level register stored reserved bits");

   AST_APB_READY: assert property ( // [R5]
      @(posedge mclk) disable iff (sys_rst)
      (psel && !penable) |=> pready_q)
      else $error("Register access not answered");

   AST_NMI_OVER_MASK: assert property ( // [R9]
      @(posedge mclk) disable iff (sys_rst)
      (nmi_req && cpu_imask) |=> (irq_nmi_q && irq_level_q == lvl_2))
      else $error("NMI blocked by global mask");

   AST_HIGH_WINS: assert property ( // [R11]
      @(posedge mclk) disable iff (sys_rst)
      (!nmi_req && !brk_req && fwd[1] && src_lvl[1] == lvl_2) |=> (irq_level_q == lvl_2))
      else $error("Top level request lost to a lower level");

endmodule

// *** bench/ilm_core_model.sv ***
`timescale 1ns/1ns

module ilm_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Mask command from the bench
   input wire logic mask_cmd,
   // Global mask bit of the core
   output logic cpu_imask
);
   logic imask_q;
   logic imask_d;

   always_comb begin
      imask_d = mask_cmd;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         imask_q <= 1'b0;
      end else begin
         imask_q <= imask_d;
      end
   end

   assign cpu_imask = imask_q;
endmodule

// *** bench/interrupt_level_masking_test.sv ***
`timescale 1ns/1ns
`include "ilm_params.svh"

module interrupt_level_masking_test
   import ilm_pkg::*;
;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [17:0] src_req = 18'h0_0000;
   logic nmi_req = 1'b0, brk_req = 1'b0, mask_cmd = 1'b0, cpu_imask;
   logic irq_valid, irq_nmi, irq_brk;
   ilm_src_id_t irq_src;
   ilm_level_t irq_level;
   int num_errors = 0;
   int checked = 0;

   always #10 mclk = ~mclk;

   ilm_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .nmi_req(nmi_req), .brk_req(brk_req),
      .cpu_imask(cpu_imask), .irq_valid(irq_valid), .irq_nmi(irq_nmi), .irq_brk(irq_brk),
      .irq_src(irq_src), .irq_level(irq_level));

   ilm_core_model u_core (.mclk(mclk), .sys_rst(sys_rst), .mask_cmd(mask_cmd),
      .cpu_imask(cpu_imask));

   task automatic complete_run();
      if (num_errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(logic [11:0] a, logic [31:0] exp, logic exp_err);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask

   function automatic logic [9:0] irq_word(logic v, logic n, logic b, logic [4:0] s,
      logic [1:0] l);
      return {v, n, b, s, l};
   endfunction

   // Mask, requests, core mask, then the expected request word
   task automatic req(logic [1:0] blk, logic [17:0] s, logic n, logic b, logic m,
      logic [9:0] exp);
      wr(`ILM_OFF_BLOCK, {30'h0, blk});
      @(posedge mclk);
      src_req <= s;
      nmi_req <= n;
      brk_req <= b;
      mask_cmd <= m;
      repeat (3) @(posedge mclk);
      #1;
      check({22'h0, irq_valid, irq_nmi, irq_brk, irq_src, irq_level}, {22'h0, exp});
   endtask

   initial begin
      #100_000;
      num_errors++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_chk(12'(4 * i), (i == 5) ? 32'h0000_00fc : 32'h0000_0000, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         wr(12'(4 * i), 32'h0000_00e4);
      end
      wr(`ILM_OFF_LVL_E, 32'h0000_004f);
      rd_chk(`ILM_OFF_LVL_A, 32'h0000_00e4, 1'b0);
      rd_chk(`ILM_OFF_LVL_D, 32'h0000_00e4, 1'b0);
      rd_chk(`ILM_OFF_LVL_E, 32'h0000_0040, 1'b0);
      wr(`ILM_OFF_BLOCK, 32'h0000_0001);
      rd_chk(`ILM_OFF_BLOCK, 32'h0000_00fd, 1'b0);
      wr(`ILM_OFF_BLOCK, 32'h0000_0002);
      rd_chk(`ILM_OFF_BLOCK, 32'h0000_00fe, 1'b0);
      wr(12'h018, 32'h0000_00ff);
      rd_chk(12'h018, 32'h0000_0000, 1'b1);
      rd_chk(`ILM_OFF_BLOCK, 32'h0000_00fe, 1'b0);
      req(2'h0, 18'h0_0008, 0, 0, 0, irq_word(1, 0, 0, 5'h03, 2'h0));
      req(2'h1, 18'h0_0008, 0, 0, 0, irq_word(0, 0, 0, 5'h00, 2'h0));
      req(2'h1, 18'h0_0004, 0, 0, 0, irq_word(1, 0, 0, 5'h02, 2'h1));
      req(2'h2, 18'h0_0004, 0, 0, 0, irq_word(0, 0, 0, 5'h00, 2'h0));
      req(2'h3, 18'h0_0001, 0, 0, 0, irq_word(1, 0, 0, 5'h00, 2'h2));
      req(2'h0, 18'h0_0006, 0, 0, 0, irq_word(1, 0, 0, 5'h01, 2'h2));
      req(2'h0, 18'h1_0004, 0, 0, 0, irq_word(1, 0, 0, 5'h02, 2'h1));
      req(2'h0, 18'h1_0008, 0, 0, 0, irq_word(1, 0, 0, 5'h10, 2'h1));
      req(2'h1, 18'h2_0000, 0, 0, 0, irq_word(0, 0, 0, 5'h00, 2'h0));
      req(2'h3, 18'h0_0001, 1, 0, 1, irq_word(1, 1, 0, 5'h00, 2'h2));
      req(2'h3, 18'h0_0000, 0, 1, 0, irq_word(1, 0, 1, 5'h00, 2'h2));
      req(2'h0, 18'h0_0008, 0, 1, 1, irq_word(0, 0, 0, 5'h00, 2'h0));
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rd_chk(`ILM_OFF_LVL_A, 32'h0000_0000, 1'b0);
      rd_chk(`ILM_OFF_BLOCK, 32'h0000_00fc, 1'b0);
      complete_run();
   end
endmodule
